// ---- hw/tcm_defs.vh ----
// Purpose: constants for the timer compare-output block
// Assumes: 32-bit APB, one word per register
// Notes:   included by its bare name
// How it works
// - all state on mclk, tick is enable
// - channel A mode nonzero takes over pin, but PWM mode 01 only if hi
// - channel B mode nonzero takes over pin, except PWM mode 01
// - A non-PWM: off, toggle, clear, set
// - A PWM mode 01 toggles only if hi
// - A fast PWM: match action, opposite at bottom
// - A fast, compare at TOP: bottom only
// - A phase correct: up/down opposite actions
// - A phase correct, compare at TOP: at TOP
// - B non-PWM: off, toggle, clear, set
// - B fast PWM: 01 reserved, 10/11 as A
// - B fast, compare at TOP: bottom only
// - B phase correct: 01 reserved, up/down
// - B phase correct, compare at TOP: at TOP
// - control A bits 3:2 read zero
// - match flags set on compare match
// - A flag and counter clear together
// - mode select is hi bit plus two
// - fast PWM codes 3 and 7, TOP
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

`define TCM_OFF_CTRL_A    8'h24
`define TCM_OFF_CTRL_B    8'h28
`define TCM_OFF_CMP_A     8'h2C
`define TCM_OFF_CMP_B     8'h30
`define TCM_OFF_COUNT     8'h34
`define TCM_OFF_FLAGS     8'h38
`define TCM_OFF_PORT      8'h3C

`define TCM_CTRL_A_RST    8'h00
`define TCM_CTRL_A_MASK   8'hF3
`define TCM_CTRL_B_RST    8'h00
`define TCM_PORT_RST      8'h00

`define TCM_COM_A_HI      7
`define TCM_COM_A_LO      6
`define TCM_COM_B_HI      5
`define TCM_COM_B_LO      4
`define TCM_WGM_LO_HI     1
`define TCM_WGM_LO_LO     0
`define TCM_WGM_HI_BIT    3
`define TCM_RUN_BIT       0
`define TCM_FLAG_A_BIT    1
`define TCM_FLAG_B_BIT    2
`define TCM_PDATA_A_BIT   0
`define TCM_PDATA_B_BIT   1
`define TCM_PDIR_A_BIT    4
`define TCM_PDIR_B_BIT    5

`define TCM_MAX           8'hFF
`define TCM_BOTTOM        8'h00
`define TCM_TICK_DIV      8

`endif

// ---- hw/tcm_timer_compare.v ----
// Purpose: 8-bit timer with two compare-output channels and APB registers
// Assumes: mclk 250 MHz, rst async active high, tick from internal divider
// Notes:   zero-wait APB, read data captured in setup phase
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defs.vh"

module tcm_timer_compare #(
  parameter TICK_DIV = `TCM_TICK_DIV
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire        pinAOut,
  output wire        pinAOe,
  output wire        pinBOut,
  output wire        pinBOe,
  output wire        waveOutA,
  output wire        waveOutB,
  output wire        matchFlagA,
  output wire        matchFlagB
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]  ctrlA_reg;
  reg  [7:0]  ctrlB_reg;
  reg  [7:0]  cmpA_reg;
  reg  [7:0]  cmpB_reg;
  reg  [7:0]  count_reg;
  reg  [7:0]  count_next;
  reg         countUp_reg;
  reg         countUp_next;
  reg  [1:0]  flags_reg;
  reg  [7:0]  port_reg;
  reg         waveA_reg;
  reg         waveA_next;
  reg         waveB_reg;
  reg         waveB_next;
  reg  [15:0] div_reg;
  reg         tick_reg;
  reg         blockMatch_reg;

  wire        setupPhase = psel & ~penable;
  wire        wrAccess   = psel & penable & pwrite;
  wire        wrLane0    = wrAccess & pstrb[0];
  wire [7:0]  wdat       = pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and flag clear paths

  function reg_hit_f;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit_f = (addr == offset);
    end
  endfunction

  wire        hitCount = reg_hit_f(paddr, `TCM_OFF_COUNT);
  wire        hitFlags = reg_hit_f(paddr, `TCM_OFF_FLAGS);
  // a one clears only its own flag, so zeros can be written freely
  wire        clrFlagA = wrLane0 & hitFlags & wdat[`TCM_FLAG_A_BIT];
  wire        clrFlagB = wrLane0 & hitFlags & wdat[`TCM_FLAG_B_BIT];
  wire [1:0]  flagClr  = {clrFlagB, clrFlagA};
  // one genvar serves both per-channel loops
  genvar      gi;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode

  wire [1:0]  comA    = ctrlA_reg[`TCM_COM_A_HI:`TCM_COM_A_LO];
  wire [1:0]  comB    = ctrlA_reg[`TCM_COM_B_HI:`TCM_COM_B_LO];
  wire [2:0]  wgm     = {ctrlB_reg[`TCM_WGM_HI_BIT],
                         ctrlA_reg[`TCM_WGM_LO_HI:`TCM_WGM_LO_LO]};
  wire        fastPwm = (wgm[1:0] == 2'b11);
  wire        pcPwm   = (wgm[1:0] == 2'b01);
  wire        anyPwm  = fastPwm | pcPwm;
  // reserved codes 4 and 6 both behave as normal code 0, with TOP at MAX
  wire        topIsA  = (wgm == 3'd2) | (wgm == 3'd5) | (wgm == 3'd7);
  wire [7:0]  topVal  = topIsA ? cmpA_reg : `TCM_MAX;
  wire        atTop   = (count_reg == topVal);
  wire        atBot   = (count_reg == `TCM_BOTTOM);

  wire        rawMatchA = tick_reg & ~blockMatch_reg & (count_reg == cmpA_reg);
  wire        rawMatchB = tick_reg & ~blockMatch_reg & (count_reg == cmpB_reg);
  // in fast PWM the wrap from TOP is the bottom event
  wire        bottomEvt = tick_reg & fastPwm & atTop;
  wire        topEvt    = tick_reg & pcPwm & atTop;

  //////////////////////////////////////////////////////////////////////////////
  // match flags: write one clears, a match in the same cycle wins

  // flags are kept as a pair so both channels share one update
  wire [1:0]  rawMatch = {rawMatchB, rawMatchA};
  wire [1:0]  flags_next;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
      assign flags_next[gi] = rawMatch[gi] | (flags_reg[gi] & ~flagClr[gi]);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // output function, shared by both channels

  function wave_next_f;
    input       cur;
    input [1:0] com;
    input       isA;
    input       match;
    input       cmpTop;
    input       fast;
    input       pc;
    input       up;
    input       wgmHi;
    input       botE;
    input       topE;
    reg         r;
    begin
      r = cur;
      if (!fast && !pc) begin
        if (match) begin
          case (com)
            2'b01:   r = ~cur;
            2'b10:   r = 1'b0;
            2'b11:   r = 1'b1;
            default: r = cur;
          endcase
        end
      end else if (com == 2'b01) begin
        // channel B has no toggle here: the reserved code is inert
        if (isA && wgmHi && match)
          r = ~cur;
      end else if (com[1]) begin
        if (fast) begin
          if (match && !cmpTop)
            r = com[0];
          if (botE)
            r = ~com[0];
        end else begin
          if (match && !cmpTop)
            r = up ? com[0] : ~com[0];
          if (topE && cmpTop)
            r = ~com[0];
        end
      end
      wave_next_f = r;
    end
  endfunction

  always @* begin
    waveA_next = wave_next_f(waveA_reg, comA, 1'b1, rawMatchA, cmpA_reg == topVal,
                             fastPwm, pcPwm, countUp_reg, wgm[2], bottomEvt, topEvt);
    waveB_next = wave_next_f(waveB_reg, comB, 1'b0, rawMatchB, cmpB_reg == topVal,
                             fastPwm, pcPwm, countUp_reg, wgm[2], bottomEvt, topEvt);
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter sequence

  always @* begin
    count_next   = count_reg;
    countUp_next = countUp_reg;
    if (tick_reg) begin
      if (pcPwm) begin
        if (countUp_reg) begin
          if (atTop) begin
            countUp_next = 1'b0;
            count_next   = count_reg - 8'h01;
          end else begin
            count_next   = count_reg + 8'h01;
          end
        end else begin
          if (atBot) begin
            countUp_next = 1'b1;
            count_next   = count_reg + 8'h01;
          end else begin
            count_next   = count_reg - 8'h01;
          end
        end
      end else begin
        countUp_next = 1'b1;
        // clear on TOP in the same tick that raises flag A
        if (topIsA && atTop)
          count_next = `TCM_BOTTOM;
        else
          count_next = count_reg + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tick divider: the only slower rate, an enable pulse
  // the divider is 16 bits wide; larger ratios belong in a prescaler

  localparam [15:0] DIV_LAST = TICK_DIV[15:0] - 16'h0001;

  // restarts while the run bit is low, so the first tick is a full period away
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (!ctrlB_reg[`TCM_RUN_BIT]) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg >= DIV_LAST) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes and timer state

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlA_reg      <= `TCM_CTRL_A_RST;
      ctrlB_reg      <= `TCM_CTRL_B_RST;
      cmpA_reg       <= `TCM_BOTTOM;
      cmpB_reg       <= `TCM_BOTTOM;
      count_reg      <= `TCM_BOTTOM;
      countUp_reg    <= 1'b1;
      flags_reg      <= 2'b00;
      port_reg       <= `TCM_PORT_RST;
      waveA_reg      <= 1'b0;
      waveB_reg      <= 1'b0;
      blockMatch_reg <= 1'b0;
    end else begin
      waveA_reg   <= waveA_next;
      waveB_reg   <= waveB_next;
      countUp_reg <= countUp_next;
      if (tick_reg)
        blockMatch_reg <= 1'b0;
      // a software write to the counter wins over counting and
      // hides the match on the next tick
      if (wrLane0 && hitCount) begin
        count_reg      <= wdat;
        blockMatch_reg <= 1'b1;
      end else begin
        count_reg <= count_next;
      end
      if (wrLane0) begin
        case (paddr)
          `TCM_OFF_CTRL_A: ctrlA_reg <= wdat & `TCM_CTRL_A_MASK;
          `TCM_OFF_CTRL_B: ctrlB_reg <= wdat;
          `TCM_OFF_CMP_A:  cmpA_reg  <= wdat;
          `TCM_OFF_CMP_B:  cmpB_reg  <= wdat;
          `TCM_OFF_PORT:   port_reg  <= wdat;
          default:         ;
        endcase
      end
      flags_reg <= flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read path, captured in setup so the access phase needs no wait

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= 1'b0;
      case (paddr)
        `TCM_OFF_CTRL_A: prdata <= {24'h000000, ctrlA_reg};
        `TCM_OFF_CTRL_B: prdata <= {24'h000000, ctrlB_reg};
        `TCM_OFF_CMP_A:  prdata <= {24'h000000, cmpA_reg};
        `TCM_OFF_CMP_B:  prdata <= {24'h000000, cmpB_reg};
        `TCM_OFF_COUNT:  prdata <= {24'h000000, count_reg};
        `TCM_OFF_FLAGS:  prdata <= {29'h00000000, flags_reg, 1'b0};
        `TCM_OFF_PORT:   prdata <= {24'h000000, port_reg};
        default: begin
          prdata  <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  assign pready = psel & penable;

  //////////////////////////////////////////////////////////////////////////////
  // pin muxing: the direction bit alone decides whether the pin drives

  // PWM mode 01 keeps the port for B always, and for A unless the top select bit is set
  function conn_f;
    input [1:0] com;
    input       isA;
    input       pwm;
    input       wgmHi;
    begin
      if (com == 2'b00)
        conn_f = 1'b0;
      else if (pwm && com == 2'b01)
        conn_f = isA & wgmHi;
      else
        conn_f = 1'b1;
    end
  endfunction

  wire [1:0]  chanConn;
  wire [1:0]  chanWave = {waveB_reg, waveA_reg};
  wire [1:0]  portData = {port_reg[`TCM_PDATA_B_BIT], port_reg[`TCM_PDATA_A_BIT]};
  wire [1:0]  portDir  = {port_reg[`TCM_PDIR_B_BIT], port_reg[`TCM_PDIR_A_BIT]};
  wire [1:0]  pinOut;

  assign chanConn[0] = conn_f(comA, 1'b1, anyPwm, wgm[2]);
  assign chanConn[1] = conn_f(comB, 1'b0, anyPwm, wgm[2]);

  // both channels share one mux shape
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      assign pinOut[gi] = chanConn[gi] ? chanWave[gi] : portData[gi];
    end
  endgenerate

  assign pinAOut    = pinOut[0];
  assign pinBOut    = pinOut[1];
  assign pinAOe     = portDir[0];
  assign pinBOe     = portDir[1];
  assign waveOutA   = waveA_reg;
  assign waveOutB   = waveB_reg;
  assign matchFlagA = flags_reg[0];
  assign matchFlagB = flags_reg[1];

endmodule // tcm_timer_compare

`default_nettype wire

// ---- sim/tcm_pin_model.sv ----
// Purpose: port pin with pull-up on the far side of a compare channel
// Assumes: pad level is resolved here from the pin enable
// Notes:   one instance per channel pin
`timescale 1ns/1ns
`default_nettype none
module tcm_pin_model (
  input  wire logic oe,
  input  wire logic drv,
  output wire logic pad
);
  // a released pin rises on the pull-up, so a stale driven level never lingers
  assign pad = oe ? drv : 1'b1;
endmodule // tcm_pin_model
`default_nettype wire

// ---- sim/tcm_chk_assertions.sv ----
// Purpose: port-level checks for the timer compare block
// Assumes: control A is shadowed from APB writes
// Notes:   bound into the top module
`timescale 1ns/1ns
`default_nettype none
module tcm_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pinAOut,
  input wire logic        pinBOut,
  input wire logic        waveOutA,
  input wire logic        waveOutB,
  input wire logic        matchFlagA,
  input wire logic        matchFlagB
);
  logic [7:0] ctrlA_reg;
  logic       wrEn;
  logic       nonPwm;
  assign wrEn = psel && penable && pwrite && pstrb[0];
  // low select bits zero means normal or the reserved code 4, both non-PWM
  assign nonPwm = ctrlA_reg[1:0] == 2'b00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      ctrlA_reg <= 8'h00;
    else if (wrEn && paddr == 8'h24)
      ctrlA_reg <= pwdata[7:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  pin_a_mux_a: assert property (ctrlA_reg[7] |-> pinAOut == waveOutA)
    else $error("pin A not on wave");
  pin_b_mux_a: assert property (ctrlA_reg[5] |-> pinBOut == waveOutB)
    else $error("pin B not on wave");
  res_bits_zero_a: assert property (psel && penable && !pwrite && paddr == 8'h24
    |-> prdata[3:2] == 2'b00) else $error("reserved bits read nonzero");
  clr_a_norise_a: assert property (nonPwm && ctrlA_reg[7:6] == 2'b10
    |=> !$rose(waveOutA)) else $error("wave A rose in clear mode");
  set_a_nofall_a: assert property (nonPwm && ctrlA_reg[7:6] == 2'b11
    |=> !$fell(waveOutA)) else $error("wave A fell in set mode");
  clr_b_norise_a: assert property (nonPwm && ctrlA_reg[5:4] == 2'b10
    |=> !$rose(waveOutB)) else $error("wave B rose in clear mode");
  tog_b_flag_a: assert property (nonPwm && ctrlA_reg[5:4] == 2'b01
    && $changed(waveOutB) |-> matchFlagB) else $error("toggle without flag B");
  flag_a_sticky_a: assert property (matchFlagA && !(wrEn && paddr == 8'h38)
    |=> matchFlagA) else $error("flag A dropped");
  cover property ($rose(matchFlagA));
  cover property ($rose(waveOutB));
  cover property ($fell(waveOutA));
endmodule // tcm_chk
bind tcm_timer_compare tcm_chk u_chk (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the timer compare block
// Assumes: tick every mclk, pins pulled up when released
// Notes:   duty counted over whole periods, so phase does not matter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         pinAOut;
  wire         pinAOe;
  wire         pinBOut;
  wire         pinBOe;
  wire         padA;
  wire         padB;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count = 0;
  int          samples_checked = 0;
  tcm_timer_compare #(.TICK_DIV(1)) u_dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinAOut(pinAOut),
    .pinAOe(pinAOe), .pinBOut(pinBOut), .pinBOe(pinBOe), .waveOutA(), .waveOutB(),
    .matchFlagA(), .matchFlagB());
  tcm_pin_model u_pinA (.oe(pinAOe), .drv(pinAOut), .pad(padA));
  tcm_pin_model u_pinB (.oe(pinBOe), .drv(pinBOut), .pad(padB));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_duty(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH %0t high count %0d exp %0d", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // stop, load compares and mode, restart from zero, then count pad highs
  task run_case(input logic [7:0] ca, input logic hi, input int c, d, w, ea, eb);
    int ha;
    int hb;
    ha = 0;
    hb = 0;
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h2C, c);
    apb(1'b1, 8'h30, d);
    apb(1'b1, 8'h24, {24'h0, ca});
    apb(1'b1, 8'h34, 32'h0);
    apb(1'b1, 8'h28, {28'h0, hi, 3'b001});
    repeat (600) @(posedge mclk);
    repeat (w) begin
      @(posedge mclk);
      ha += (padA === 1'b1);
      hb += (padB === 1'b1);
    end
    chk_duty(ha, ea);
    chk_duty(hb, eb);
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    close_out();
  end
  initial begin
    int c;
    int d;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    void'($urandom(80));
    c = 2 + $urandom % 250;
    d = 2 + $urandom % 250;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h24, 32'h0);
    chk_reg(rdat, 32'h0);
    apb(1'b1, 8'h24, 32'hFF);
    apb(1'b0, 8'h24, 32'h0);
    chk_reg(rdat, 32'hF3);
    apb(1'b0, 8'h00, 32'h0);
    chk_reg({31'h0, rerr}, 32'h1);
    apb(1'b1, 8'h3C, 32'h31);
    run_case(8'hB3, 1'b0, c, d, 256, c + 1, 255 - d);
    run_case(8'hE1, 1'b0, c, d, 510, 510 - 2 * c, 2 * d);
    run_case(8'h52, 1'b0, c, c / 2, 2 * c + 2, c + 1, c + 1);
    run_case(8'h63, 1'b1, c, c / 2, 2 * c + 2, c + 1, 2 * (c / 2) + 2);
    run_case(8'h53, 1'b0, c, d, 256, 256, 0);
    run_case(8'hB3, 1'b0, 255, 255, 256, 256, 0);
    run_case(8'hB1, 1'b0, 255, 255, 510, 510, 0);
    run_case(8'hB0, 1'b0, c, d, 256, 0, 256);
    run_case(8'hE0, 1'b0, c, d, 256, 256, 0);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk_reg(rdat, 32'h6);
    apb(1'b1, 8'h38, 32'h6);
    apb(1'b0, 8'h38, 32'h0);
    chk_reg(rdat, 32'h0);
    apb(1'b1, 8'h24, 32'h0);
    apb(1'b1, 8'h3C, 32'h0);
    @(posedge mclk);
    chk_reg({31'h0, padA}, 32'h1);
    close_out();
  end
endmodule // testbench
`default_nettype wire
